// ---- hdl/mslo_strobe_lanes.sv ----
// Purpose: drive lane strobes, byte selects, general lines, card strobes
// Assumes: request inputs come from same-clock controller logic
// Notes: all pins active low, idle high except upper general lines in chip-select mode; lane strobes and upper general lines are shared between functions
`timescale 1ns/100ps
module mslo_strobe_lanes (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // access request from the controllers
  input wire logic [2:0] access_owner,
  input wire logic access_active,
  input wire logic access_write,
  input wire logic access_card_io,
  input wire logic [3:0] lane_valid,
  // user machine program words, active high meaning asserted
  input wire logic [3:0] mach_a_select_prog,
  input wire logic [3:0] mach_b_select_prog,
  input wire logic [3:0] mach_a_general_prog,
  input wire logic [3:0] mach_b_general_prog,
  // shared pin configuration and chip-select hits
  input wire logic [1:0] hi_lines_select,
  input wire logic [1:0] chipsel_hit,
  // pins, active low
  output logic lane0_write_strobe_n,
  output logic lane1_write_strobe_n,
  output logic lane2_write_strobe_n,
  output logic lane3_write_strobe_n,
  output logic [3:0] machine_a_lane_selects_n,
  output logic general_line0_n,
  output logic general_line1_n,
  output logic [1:0] general_lines_hi_n
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [3:0] shared_lane;
    logic [3:0] a_sel;
    logic gl0;
    logic gl1;
    logic [1:0] ghi;
  } mslo_state_t;

  mslo_state_t st_reg, st_next;
  logic rst_n;
  logic [1:0] rsync_reg;
  logic own_cs, own_a, own_b, own_card;
  logic card_rd_io, card_wr_io, card_rd_mem, card_wr_mem;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsync_reg <= 2'h0;
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end
  assign rst_n = rsync_reg[1];

  assign own_cs = access_active &&
    access_owner == mslo_pkg::MSLO_OWN_CHIPSEL_MACH;
  assign own_a = access_active && access_owner == mslo_pkg::MSLO_OWN_UMA;
  assign own_b = access_active && access_owner == mslo_pkg::MSLO_OWN_UMB;
  assign own_card = access_active &&
    access_owner == mslo_pkg::MSLO_OWN_CARD;
  assign card_rd_io = own_card && !access_write && access_card_io;
  assign card_wr_io = own_card && access_write && access_card_io;
  assign card_rd_mem = own_card && !access_write && !access_card_io;
  assign card_wr_mem = own_card && access_write && !access_card_io;

  always_comb begin
    st_next = st_reg;
    st_next.rst_sync = 2'h0;
    st_next.shared_lane = mslo_pkg::LANES_IDLE;
    st_next.a_sel = mslo_pkg::LANES_IDLE;
    st_next.gl0 = 1'b1;
    st_next.gl1 = 1'b1;
    st_next.ghi = mslo_pkg::GP_HI_IDLE;
    if (own_cs && access_write) begin
      st_next.shared_lane = ~lane_valid;
    end else if (own_b) begin
      st_next.shared_lane = ~(mach_b_select_prog & lane_valid);
    end else if (own_card) begin
      st_next.shared_lane[0] = !card_rd_io;
      st_next.shared_lane[1] = !card_wr_io;
      st_next.shared_lane[2] = !card_rd_mem;
      st_next.shared_lane[3] = !card_wr_mem;
    end
    if (own_a) begin
      st_next.a_sel = ~(mach_a_select_prog & lane_valid);
    end
    if (own_a) begin
      st_next.gl0 = !mach_a_general_prog[0];
      st_next.gl1 = !mach_a_general_prog[1];
    end else if (own_b) begin
      st_next.gl0 = !mach_b_general_prog[0];
      st_next.gl1 = !mach_b_general_prog[1];
    end else if (own_cs && !access_write) begin
      st_next.gl1 = 1'b0;
    end
    if (hi_lines_select == mslo_pkg::MSLO_HI_CHIPSEL) begin
      st_next.ghi = ~chipsel_hit;
    end else if (hi_lines_select == mslo_pkg::MSLO_HI_MACH_A && own_a) begin
      st_next.ghi = ~mach_a_general_prog[3:2];
    end else if (hi_lines_select == mslo_pkg::MSLO_HI_MACH_B && own_b) begin
      st_next.ghi = ~mach_b_general_prog[3:2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{rst_sync: 2'h0, shared_lane: mslo_pkg::LANES_IDLE,
        a_sel: mslo_pkg::LANES_IDLE, gl0: 1'b1, gl1: 1'b1,
        ghi: mslo_pkg::GP_HI_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lane0_write_strobe_n = st_reg.shared_lane[0];
  assign lane1_write_strobe_n = st_reg.shared_lane[1];
  assign lane2_write_strobe_n = st_reg.shared_lane[2];
  assign lane3_write_strobe_n = st_reg.shared_lane[3];
  assign machine_a_lane_selects_n = st_reg.a_sel;
  assign general_line0_n = st_reg.gl0;
  assign general_line1_n = st_reg.gl1;
  assign general_lines_hi_n = st_reg.ghi;

  cs_write_lanes_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_cs && access_write |=> st_reg.shared_lane == ~$past(lane_valid))
    else $error("chip-select write lanes wrong");
  cs_read_oe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_cs && !access_write |=> !general_line1_n)
    else $error("output enable missing");
  mach_b_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_b |=> st_reg.shared_lane ==
      ~($past(mach_b_select_prog) & $past(lane_valid)))
    else $error("machine b select wrong");
  mach_a_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !own_a |=> machine_a_lane_selects_n == mslo_pkg::LANES_IDLE)
    else $error("machine a select stray");
  card_io_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    card_rd_io |=> !lane0_write_strobe_n && lane2_write_strobe_n)
    else $error("card io read wrong");
  card_io_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    card_wr_io |=> !lane1_write_strobe_n && lane3_write_strobe_n)
    else $error("card io write wrong");
  card_mem_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    card_rd_mem |=> !lane2_write_strobe_n && lane0_write_strobe_n)
    else $error("card memory read wrong");
  card_mem_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    card_wr_mem |=> !lane3_write_strobe_n && lane1_write_strobe_n)
    else $error("card memory write wrong");
  chipsel_hi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    hi_lines_select == mslo_pkg::MSLO_HI_CHIPSEL |=>
      general_lines_hi_n == ~$past(chipsel_hit))
    else $error("chip select lines wrong");
  idle_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !access_active && hi_lines_select != mslo_pkg::MSLO_HI_CHIPSEL |=>
      st_reg.shared_lane == mslo_pkg::LANES_IDLE &&
      general_lines_hi_n == mslo_pkg::GP_HI_IDLE)
    else $error("idle pins not high");

  // machine a selects follow program, valid lanes only
  mach_a_lanes_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_a |=> machine_a_lane_selects_n ==
      ~($past(mach_a_select_prog) & $past(lane_valid)))
    else $error("machine a lanes wrong");

  // general lines 0 and 1 follow the owning machine
  mach_a_gen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_a |=> general_line0_n == !$past(mach_a_general_prog[0]) &&
      general_line1_n == !$past(mach_a_general_prog[1]))
    else $error("machine a general lines wrong");
  mach_b_gen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_b |=> general_line0_n == !$past(mach_b_general_prog[0]) &&
      general_line1_n == !$past(mach_b_general_prog[1]))
    else $error("machine b general lines wrong");

  // upper general lines when configured for a machine
  mach_a_hi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_a && hi_lines_select == mslo_pkg::MSLO_HI_MACH_A |=>
      general_lines_hi_n == ~$past(mach_a_general_prog[3:2]))
    else $error("machine a upper lines wrong");
  mach_b_hi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_b && hi_lines_select == mslo_pkg::MSLO_HI_MACH_B |=>
      general_lines_hi_n == ~$past(mach_b_general_prog[3:2]))
    else $error("machine b upper lines wrong");

  // card access drives exactly one shared strobe
  card_one_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_card |=> $countones(~st_reg.shared_lane) == 1)
    else $error("card strobes not exclusive");

  // chip-select read leaves every write strobe high
  cs_read_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    own_cs && !access_write |=> st_reg.shared_lane == mslo_pkg::LANES_IDLE)
    else $error("write strobe on read");

  // no access: machine pins stay negated
  no_owner_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !access_active |=> general_line0_n && general_line1_n &&
      machine_a_lane_selects_n == mslo_pkg::LANES_IDLE)
    else $error("machine pins active while idle");
endmodule

// ---- hdl/mslo_pkg.sv ----
// Purpose: shared constants for the memory strobe lane output block
// Assumes: strobes are active low on the pins
// Notes: owner and pin-function encodings
package mslo_pkg;
  localparam int LANES = 4;
  localparam logic [3:0] LANES_IDLE = 4'hf;
  localparam logic [1:0] GP_HI_IDLE = 2'h3;
  // which controller owns the current access
  typedef enum logic [2:0] {
    MSLO_OWN_NONE = 3'b000,
    MSLO_OWN_CHIPSEL_MACH = 3'b001,
    MSLO_OWN_UMA = 3'b010,
    MSLO_OWN_UMB = 3'b011,
    MSLO_OWN_CARD = 3'b100
  } mslo_owner_t;
  // function of the shared general lines 2 and 3
  typedef enum logic [1:0] {
    MSLO_HI_MACH_A = 2'b00,
    MSLO_HI_MACH_B = 2'b01,
    MSLO_HI_CHIPSEL = 2'b10
  } mslo_hi_sel_t;
endpackage

// ---- tb/mslo_mem_model.sv ----
// Purpose: far-side memory that stores the lanes strobed for writing
// Assumes: write strobes active low, sampled on the clock
// Notes: shows which lanes the last write edge stored
`timescale 1ns/100ps
module mslo_mem_model (
  // clock
  input wire logic core_clk,
  // lane write strobes from the block
  input wire logic [3:0] we_n,
  // lanes stored at the last edge
  output logic [3:0] lanes_stored
);
  always_ff @(posedge core_clk) begin
    lanes_stored <= ~we_n;
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the strobe lane block
// Assumes: outputs answer one cycle after inputs
// Notes: one task per scenario
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  logic core_clk = 0, resetn = 0, act = 0, wr = 0, io = 0;
  logic [2:0] own = 3'h0;
  logic [3:0] lv = 4'h0, asel = 4'h0, bsel = 4'h0, agen = 4'h0, bgen = 4'h0;
  logic [1:0] hs = 2'h0, hit = 2'h0;
  logic w0, w1, w2, w3, g0, g1;
  logic [3:0] as_n, stored;
  logic [1:0] ghi;
  wire [11:0] pins = {w3, w2, w1, w0, as_n, g0, g1, ghi};
  int miscompares = 0, n_tests = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  mslo_strobe_lanes i_mslo_strobe_lanes (.core_clk(core_clk),
    .resetn(resetn), .access_owner(own), .access_active(act),
    .access_write(wr), .access_card_io(io), .lane_valid(lv),
    .mach_a_select_prog(asel), .mach_b_select_prog(bsel),
    .mach_a_general_prog(agen), .mach_b_general_prog(bgen),
    .hi_lines_select(hs), .chipsel_hit(hit), .lane0_write_strobe_n(w0),
    .lane1_write_strobe_n(w1), .lane2_write_strobe_n(w2),
    .lane3_write_strobe_n(w3), .machine_a_lane_selects_n(as_n),
    .general_line0_n(g0), .general_line1_n(g1), .general_lines_hi_n(ghi));
  mslo_mem_model i_mslo_mem_model (.core_clk(core_clk),
    .we_n({w3, w2, w1, w0}), .lanes_stored(stored));
  task drive(input [2:0] o, input a, w, i, input [3:0] v, input [1:0] h);
    @(posedge core_clk);
    {own, act, wr, io, lv, hs} <= {o, a, w, i, v, h};
    @(posedge core_clk);
    #1;
  endtask
  task t_cs_wr;
    for (int v = 0; v < 16; v++) begin
      drive(3'h1, 1, 1, 0, v[3:0], 2'h0);
      `CHK("chip-select write", {~v[3:0], 8'hff}, pins)
      @(posedge core_clk);
      #1;
      `CHK("stored lanes", v[3:0], stored)
    end
  endtask
  task t_cs_rd;
    drive(3'h1, 1, 0, 0, 4'hf, 2'h0);
    `CHK("chip-select read", 12'hffb, pins)
  endtask
  task t_mach_b;
    bsel <= 4'hb;
    bgen <= 4'h9;
    drive(3'h3, 1, 0, 0, 4'h6, 2'h1);
    `CHK("machine b", 12'hdf5, pins)
  endtask
  task t_mach_a;
    asel <= 4'he;
    agen <= 4'h6;
    drive(3'h2, 1, 1, 0, 4'hb, 2'h0);
    `CHK("machine a", 12'hf5a, pins)
  endtask
  task t_card;
    for (int k = 0; k < 4; k++) begin
      drive(3'h4, 1, k[0], ~k[1], 4'hf, 2'h0);
      `CHK("card", {~(4'h1 << k), 8'hff}, pins)
    end
  endtask
  task t_chipsel;
    hit <= 2'h2;
    drive(3'h1, 1, 1, 0, 4'h0, 2'h2);
    `CHK("chip selects", 12'hffd, pins)
  endtask
  task t_idle;
    drive(3'h0, 0, 0, 0, 4'hf, 2'h0);
    `CHK("idle", 12'hfff, pins)
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("after reset", 12'hfff, pins)
    t_cs_wr();
    t_cs_rd();
    t_mach_b();
    t_mach_a();
    t_card();
    t_chipsel();
    t_idle();
    results();
  end
endmodule
